// >>> sim/spm_host.sv
// Host controller model: clocks frames of up to 32 bits into the serial port.
// Assumes clk is the bench pclk; every pin edge is paced from it.
`timescale 1ns/1ps
`default_nettype none
module spm_host_model (
   // Pacing clock
   input wire logic clk,
   // Serial pins toward the device
   output logic sclk,
   output logic sdi,
   output logic strobe,
   // Shared pin from the device
   input wire logic pin_o,
   input wire logic pin_oe
);
   // ************************************************
   // Idle levels: clock parked low between frames
   // ************************************************
   initial begin
      sclk = 1'b0;
      sdi = 1'b0;
      strobe = 1'b0;
   end

   // ************************************************
   // One frame: n bits MSB first, then the strobe
   // ************************************************
   // Bits last 80 ns; the pin is sampled one pclk after the device's four-edge delay
   // An undriven line shows the inverse of the last level, never a stale copy
   task automatic frame(input logic [31:0] w, input int n,
                        output logic [23:0] rd, output logic drv);
      rd = '0;
      drv = 1'b0;
      @(posedge clk);
      sdi <= w[31];
      for (int i = 0; i < n; i++) begin
         repeat (5) @(posedge clk);
         sclk <= 1'b1;
         repeat (5) @(posedge clk);
         if (i < 24) begin
            rd[23-i] = pin_oe ? pin_o : ~pin_o;
         end
         if (i == 0) begin
            drv = pin_oe;
         end
         sclk <= 1'b0;
         // After the last bit the line shows the inverse, never a stale level
         sdi <= (i < n - 1) ? w[30-i] : ~w[31-i];
      end
      repeat (5) @(posedge clk);
      strobe <= 1'b1;
      repeat (5) @(posedge clk);
      strobe <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
endmodule // spm_host_model
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench: APB table first, then serial frames and pin checks.
// Assumes spm_pkg, the design and the host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spm_pkg::*;
   localparam logic [23:0] ID = 24'h3c5a99; // Arbitrary identity value
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} spm_row_s;
   // ************************************************
   // Signals
   // ************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pin_o, pin_oe, pdn;
   logic pwr_pin = 1'b1;
   logic lock = 1'b0;
   logic [5:0] keep;
   wire sclk, sdi, stb;
   int bad_count = 0;
   int check_count = 0;
   logic [23:0] rd;
   logic drv, e;
   logic [31:0] r;
   // Reset-value rows: address, expected data, expected error
   spm_row_s rows [7] = '{'{8'h00, {8'h00, ID}, 1'b0}, '{8'h04, 32'h3, 1'b0},
      '{8'h08, 32'h20, 1'b0}, '{8'h0c, 32'h1, 1'b0}, '{8'h14, 32'h0, 1'b0},
      '{8'h18, 32'h0, 1'b1}, '{8'h10, 32'h0, 1'b0}};

   always #4 pclk = ~pclk;

   spm_top #(.DEV_ID(ID)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_pin(sclk),
      .sdi_pin(sdi), .frame_latch_strobe(stb), .shared_lock_and_read_pin_o(pin_o),
      .shared_lock_and_read_pin_oe(pin_oe), .power_control_pin(pwr_pin),
      .lock_detect(lock), .power_down(pdn), .block_keep_on(keep));

   spm_host_model u_host (.clk(pclk), .sclk(sclk), .sdi(sdi), .strobe(stb),
      .pin_o(pin_o), .pin_oe(pin_oe));

   // ************************************************
   // Tasks
   // ************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   // One APB transfer; waits for pready with a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n >= 20) begin
         chk(0, 1, "apb timeout");
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic sf(input logic [23:0] d, input logic [4:0] a, input logic [2:0] c);
      u_host.frame({d, a, c}, 32, rd, drv);
   endtask

   task automatic pin(input logic oe, input logic o, input string m);
      repeat (10) @(posedge pclk);
      chk(pin_oe, oe, m);
      if (oe) begin
         chk(pin_o, o, m);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pin_oe, 0, "oe after reset");
      chk(pdn, 0, "pd after reset");
      chk(keep, 6'h3f, "keep after reset");
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk(r, rows[i].d, "apb data");
         chk(e, rows[i].e, "apb error");
      end
      // Foreign chip: no write, no drive
      sf(24'h0000a5, 5'h01, 3'h1);
      chk(drv, 0, "first frame drove");
      apb(1'b0, 8'h04, 32'h0);
      chk(r, 32'h3, "foreign write landed");
      sf(24'h0000ff, 5'h01, 3'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(r, 32'hff, "frame write");
      // Two-cycle read, pointer 1; the second frame repeats the first
      sf(24'h000001, 5'h00, 3'h0);
      chk(rd, ID, "identity via pin");
      sf(24'h000001, 5'h00, 3'h0);
      chk(drv, 1, "read not driven");
      chk(rd, 24'h0000ff, "read data");
      pin(0, 0, "oe after strobe");
      // Foreign frame must not select nor move the pointer
      sf(24'h00000f, 5'h00, 3'h5);
      sf(24'h000020, 5'h08, 3'h0);
      chk(drv, 0, "foreign frame selected");
      sf(24'h000001, 5'h00, 3'h0);
      chk(rd, 24'h0000ff, "pointer moved");
      // Strobe after only eight zero bits still selects
      sf(24'h000000, 5'h00, 3'h5);
      u_host.frame(32'h0, 8, rd, drv);
      sf(24'h000001, 5'h00, 3'h0);
      chk(drv, 1, "early strobe");
      // Master enable off overrides all
      sf(24'h000000, 5'h08, 3'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(r, 32'h0, "reg08 write");
      sf(24'h000001, 5'h00, 3'h0);
      chk(drv, 0, "master off drove");
      sf(24'h000020, 5'h08, 3'h0);
      // Force and hold: general output everywhere
      lock <= 1'b1;
      sf(24'h0000c1, 5'h0f, 3'h0);
      pin(1, 1, "force lock");
      sf(24'h000001, 5'h00, 3'h0);
      chk(rd, 24'hffffff, "hold select");
      lock <= 1'b0;
      pin(1, 0, "force lock low");
      // Pull halves
      sf(24'h0001c1, 5'h0f, 3'h0);
      lock <= 1'b1;
      pin(0, 0, "pull-up off");
      lock <= 1'b0;
      pin(1, 0, "pull-down on");
      sf(24'h0002c1, 5'h0f, 3'h0);
      pin(0, 0, "pull-down off");
      lock <= 1'b1;
      pin(1, 1, "pull-up on");
      // Selector picks a source bit
      sf(24'h0000c3, 5'h0f, 3'h0);
      apb(1'b1, 8'h14, 32'h8);
      pin(1, 1, "selector 3 high");
      apb(1'b1, 8'h14, 32'h0);
      pin(1, 0, "selector 3 low");
      sf(24'h000001, 5'h0f, 3'h0);
      pin(0, 0, "tri-state restored");
      // Power-down and keep-on
      pwr_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      chk(pdn, 1, "pin power down");
      chk(keep, 6'h3f, "keep all");
      sf(24'h00000b, 5'h01, 3'h0);
      chk(keep, 6'h02, "keep one");
      sf(24'h000002, 5'h01, 3'h0);
      chk(pdn, 0, "soft enable");
      pwr_pin <= 1'b1;
      sf(24'h000000, 5'h01, 3'h0);
      chk(pdn, 1, "soft disable");
      // Soft reset restores defaults
      sf(24'h000020, 5'h00, 3'h0);
      apb(1'b0, 8'h04, 32'h0);
      chk(r, 32'h3, "soft reset 01");
      apb(1'b0, 8'h0c, 32'h0);
      chk(r, 32'h1, "soft reset 0f");
      // Mid-run reset while the forced driver is on
      sf(24'h0000c1, 5'h0f, 3'h0);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      chk(pin_oe, 0, "oe after mid reset");
      apb(1'b0, 8'h0c, 32'h0);
      chk(r, 32'h1, "reg0f after mid reset");
      final_report();
   end

   // Watchdog: the whole run needs well under this span
   initial begin
      #400us;
      bad_count++;
      final_report();
   end
endmodule // tb_top
`default_nettype wire

// >>> src/spm_map.svh
// Register offsets, field positions and reset values of the serial port block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// ************************************************
// APB byte offsets
// ************************************************
`define SPM_A_ID 8'h00
`define SPM_A_ENABLE 8'h04
`define SPM_A_DRVCFG 8'h08
`define SPM_A_OUTCFG 8'h0c
`define SPM_A_STATUS 8'h10
`define SPM_A_SRC 8'h14

// ************************************************
// Serial register indices and fields
// ************************************************
`define SPM_REG_ID 5'h00
`define SPM_REG_EN 5'h01
`define SPM_REG_DRV 5'h08
`define SPM_REG_OUT 5'h0f
`define SPM_R0_SRST 5
`define SPM_EN_PINSEL 0
`define SPM_EN_SWEN 1
`define SPM_EN_KEEP_GPO 7
`define SPM_DRV_MASTER 5
`define SPM_OUT_HOLD 6
`define SPM_OUT_FORCE 7
`define SPM_OUT_PUDIS 8
`define SPM_OUT_PDDIS 9
`define SPM_CHIP_ADDR 3'h0
`define SPM_FRAME_BITS 6'd32

// ************************************************
// Reset values
// ************************************************
`define SPM_RST_R01 24'h000003
`define SPM_RST_R02 24'h000001
`define SPM_RST_R03 24'h000019
`define SPM_RST_R06 24'h030f0a
`define SPM_RST_R08 24'h000020
`define SPM_RST_R0F 24'h000001
`define SPM_RST_SRC 32'h00000000

`endif

// >>> src/spm_pin_drv.sv
// Shared output pin driver with separate pull-up and pull-down halves.
// Assumes enable and data come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module spm_pin_drv (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Drive request
   input wire logic en,
   input wire logic dat,
   input wire logic pu_dis,
   input wire logic pd_dis,
   // Pin
   output logic pin_o,
   output logic pin_oe
);
   // Bit 1 enable, bit 0 level
   logic [1:0] pin_d;
   logic [1:0] pin_q;

   // ************************************************
   // Half-driver gating
   // ************************************************
   // A disabled half leaves the line floating rather than fighting a pull
   always_comb begin
      pin_d[0] = dat;
      pin_d[1] = en & (dat ? !pu_dis : !pd_dis);
   end

   // Registered so the pin never glitches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_q <= 2'h0;
      end else begin
         pin_q <= pin_d;
      end
   end

   assign pin_o = pin_q[0];
   assign pin_oe = pin_q[1];
endmodule // spm_pin_drv
`default_nettype wire

// >>> src/spm_pkg.sv
// Types shared by the serial port block.
// Assumes spm_map.svh is on the include path.
package spm_pkg;
   `include "spm_map.svh"

   // Frame progress, Gray coded along idle, shift, full
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_SHIFT = 2'b01,
      FR_FULL = 2'b11
   } spm_frame_e;

   // Whole state of the top module
   typedef struct packed {
      logic [31:0][23:0] regs;
      logic [4:0] ptr;
      logic [31:0] shift;
      logic [5:0] cnt;
      spm_frame_e frame;
      logic [23:0] rdw;
      logic sdo_bit;
      logic sel;
      logic rd;
      logic sclk_p;
      logic sen_p;
      logic pd;
      logic [5:0] keep;
      logic [31:0] src;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } spm_state_s;
endpackage

// >>> src/spm_sync.sv
// Two-stage synchroniser for levels entering the pclk domain.
// Assumes inputs are asynchronous levels; only the second stage is read outside.
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // First stage, read only by the second
   logic [W-1:0] meta_q;

   // ************************************************
   // Sync chain
   // ************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // spm_sync
`default_nettype wire

// >>> src/spm_top.sv
// Serial control port and shared lock/read output pin with power controls.
// Assumes serial pins are asynchronous to pclk and at most a quarter its rate.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Offsets, fields and reset values; the guard makes a second inclusion harmless
`include "spm_map.svh"
module spm_top
   import spm_pkg::*;
#(
   parameter logic [23:0] DEV_ID = 24'h5a3c01 // Arbitrary identity value
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial link pins
   input wire logic sclk_pin,
   input wire logic sdi_pin,
   input wire logic frame_latch_strobe,
   // Shared lock and read pin
   output logic shared_lock_and_read_pin_o,
   output logic shared_lock_and_read_pin_oe,
   // Power and status
   input wire logic power_control_pin,
   input wire logic lock_detect,
   output logic power_down,
   output logic [5:0] block_keep_on
);
   spm_state_s s_q; // Registered state
   spm_state_s s_d; // Next state
   logic sclk_s, sdi_s, sen_s, cen_s, lock_s; // Synchronised pins
   logic sclk_rise, sen_rise; // Link edges
   logic [4:0] waddr; // Frame register address
   logic [23:0] wdata; // Frame data
   logic [23:0] rd_word; // Word the pointer names
   logic [31:0] src_vec; // General output sources
   logic general_output_signal; // Selected general output
   logic pd_now; // Power-down request
   logic drv_en, drv_dat; // Pin request

   // Default register image, also the soft-reset image
   function automatic logic [31:0][23:0] reg_defaults();
      logic [31:0][23:0] r;
      r = '0;
      r[1] = `SPM_RST_R01;
      r[2] = `SPM_RST_R02;
      r[3] = `SPM_RST_R03;
      r[6] = `SPM_RST_R06;
      r[8] = `SPM_RST_R08;
      r[15] = `SPM_RST_R0F; // Selector defaults to lock detect
      return r;
   endfunction

   // ************************************************
   // Pin synchronisers
   // ************************************************
   spm_sync #(.W(5)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d({sclk_pin, sdi_pin, frame_latch_strobe, power_control_pin, lock_detect}),
      .q({sclk_s, sdi_s, sen_s, cen_s, lock_s})
   );

   // ************************************************
   // Decode
   // ************************************************
   always_comb begin
      sclk_rise = sclk_s & !s_q.sclk_p;
      sen_rise = sen_s & !s_q.sen_p;
      waddr = s_q.shift[7:3];
      wdata = s_q.shift[31:8];
      // Register zero reads as identity, not as the pointer
      rd_word = (s_q.ptr == `SPM_REG_ID) ? DEV_ID : s_q.regs[s_q.ptr];
      // Lock status rides on selector value one; every other value reads a source bit
      src_vec = {s_q.src[31:2], lock_s, s_q.src[0]};
      general_output_signal = src_vec[s_q.regs[`SPM_REG_OUT][4:0]];
      // Pin-select clear ignores the pin
      pd_now = s_q.regs[`SPM_REG_EN][`SPM_EN_PINSEL] ? !cen_s
               : !s_q.regs[`SPM_REG_EN][`SPM_EN_SWEN];
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      s_d = s_q;
      s_d.sclk_p = sclk_s;
      s_d.sen_p = sen_s;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      // Power: keep-on bits override the shutdown
      s_d.pd = pd_now;
      s_d.keep = ~{6{pd_now}} | s_q.regs[`SPM_REG_EN][7:2];
      // Strobe outranks a coincident clock rise, so no frame runs past its strobe
      if (sen_rise) begin
         // Only whole frames for chip zero are latched
         if (s_q.frame == FR_FULL && s_q.shift[2:0] == `SPM_CHIP_ADDR) begin
            if (waddr == `SPM_REG_ID) begin
               s_d.ptr = wdata[4:0];
               if (wdata[`SPM_R0_SRST]) begin
                  s_d.regs = reg_defaults();
               end
            end else begin
               s_d.regs[waddr] = wdata;
            end
         end
         // Zero-filled shift also catches an early strobe
         s_d.sel = (s_q.shift[2:0] == `SPM_CHIP_ADDR);
         s_d.rd = 1'b0;
         s_d.frame = FR_IDLE;
         s_d.shift = '0;
         s_d.cnt = '0;
      end else if (sclk_rise) begin
         // Data taken on rising edges only
         s_d.shift = {s_q.shift[30:0], sdi_s};
         case (s_q.frame)
            // First edge: snapshot word and present its top bit
            FR_IDLE: begin
               s_d.frame = FR_SHIFT;
               s_d.cnt = 6'd1;
               s_d.rd = s_q.sel;
               s_d.sdo_bit = rd_word[23];
               s_d.rdw = {rd_word[22:0], 1'b0};
            end
            // Later edges: next bit, zeros after the word
            FR_SHIFT: begin
               s_d.cnt = s_q.cnt + 6'd1;
               s_d.sdo_bit = s_q.rdw[23];
               s_d.rdw = {s_q.rdw[22:0], 1'b0};
               if (s_q.cnt == `SPM_FRAME_BITS - 6'd1) begin
                  s_d.frame = FR_FULL;
               end
            end
            // Extra edges keep shifting; the last 32 bits count
            FR_FULL: begin
               s_d.sdo_bit = 1'b0;
            end
            default: begin
               s_d.frame = FR_IDLE;
            end
         endcase
      end
      // APB access phase: answer one cycle later from flops
      if (psel && penable && !s_q.pready) begin
         s_d.pready = 1'b1;
         s_d.prdata = '0;
         case (paddr)
            `SPM_A_ID: s_d.prdata = {8'h00, DEV_ID};
            `SPM_A_ENABLE: s_d.prdata = {8'h00, s_q.regs[`SPM_REG_EN]};
            `SPM_A_DRVCFG: s_d.prdata = {8'h00, s_q.regs[`SPM_REG_DRV]};
            `SPM_A_OUTCFG: s_d.prdata = {8'h00, s_q.regs[`SPM_REG_OUT]};
            `SPM_A_STATUS: s_d.prdata = {16'h0000, s_q.frame, s_q.rd, s_q.sel, s_q.pd,
                                         s_q.ptr, s_q.cnt};
            `SPM_A_SRC: s_d.prdata = s_q.src;
            default: s_d.pslverr = 1'b1;
         endcase
      end
      // Write takes effect on the completing edge
      if (psel && penable && s_q.pready && pwrite && paddr == `SPM_A_SRC) begin
         s_d.src = pwdata;
      end
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0; // Driver quiet after reset
         s_q.regs <= reg_defaults();
         s_q.src <= `SPM_RST_SRC;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************
   // Output mux and driver
   // ************************************************
   // Master enable wins; power-down silences unless kept on
   always_comb begin
      drv_en = s_q.regs[`SPM_REG_DRV][`SPM_DRV_MASTER]
               & (!s_q.pd | s_q.regs[`SPM_REG_EN][`SPM_EN_KEEP_GPO])
               & (s_q.rd | s_q.regs[`SPM_REG_OUT][`SPM_OUT_FORCE]);
      drv_dat = (s_q.rd && !s_q.regs[`SPM_REG_OUT][`SPM_OUT_HOLD]) ? s_q.sdo_bit : general_output_signal;
   end

   spm_pin_drv u_drv (
      .clk(pclk),
      .rst_n(presetn),
      .en(drv_en),
      .dat(drv_dat),
      .pu_dis(s_q.regs[`SPM_REG_OUT][`SPM_OUT_PUDIS]),
      .pd_dis(s_q.regs[`SPM_REG_OUT][`SPM_OUT_PDDIS]),
      .pin_o(shared_lock_and_read_pin_o),
      .pin_oe(shared_lock_and_read_pin_oe)
   );

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign power_down = s_q.pd;
   assign block_keep_on = s_q.keep;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_write_lands: assert property (sen_rise && s_q.frame == FR_FULL
      && s_q.shift[2:0] == 3'h0 && waddr != 5'h00
      |=> s_q.regs[$past(waddr)] == $past(wdata))
      else $error("frame not latched");
   a_foreign_frame: assert property (sen_rise && s_q.shift[2:0] != 3'h0
      |=> $stable(s_q.regs) && !s_q.sel ##1 !s_q.rd)
      else $error("foreign frame acted on");
   a_ptr_soft_rst: assert property (sen_rise && s_q.frame == FR_FULL
      && s_q.shift[7:0] == 8'h00 && s_q.shift[13]
      |=> s_q.regs[1] == 24'h000003 && s_q.ptr == $past(s_q.shift[12:8]))
      else $error("soft reset or pointer wrong");
   a_read_starts: assert property (sclk_rise && !sen_rise
      && s_q.frame == FR_IDLE && s_q.sel
      |=> s_q.rd && s_q.sdo_bit == $past(rd_word[23]))
      else $error("read data not presented");
   a_read_ends: assert property (sen_rise |=> !s_q.rd)
      else $error("read not ended by strobe");
   a_master_off: assert property (!s_q.regs[8][5] |=> !shared_lock_and_read_pin_oe)
      else $error("driver on while master off");
   a_pull_up_off: assert property (shared_lock_and_read_pin_oe
      && shared_lock_and_read_pin_o |-> !$past(s_q.regs[15][8]))
      else $error("high driven with pull-up off");
   a_force_drive: assert property (s_q.regs[15][7] && s_q.regs[8][5] && !s_q.pd
      && s_q.regs[15][9:8] == 2'b00 |=> shared_lock_and_read_pin_oe)
      else $error("forced driver not on");
   a_hold_gpo: assert property (s_q.rd && s_q.regs[15][6]
      |=> !shared_lock_and_read_pin_oe || shared_lock_and_read_pin_o == $past(general_output_signal))
      else $error("hold ignored");
   a_quiet_idle: assert property (!s_q.rd && !s_q.regs[15][7]
      |=> !shared_lock_and_read_pin_oe)
      else $error("pin driven outside read");
   a_pin_select: assert property (!s_q.regs[1][0] |=> s_q.pd == !$past(s_q.regs[1][1]))
      else $error("enable bit not obeyed");
   // The reset image holds keep at zero, so the first edge after release is skipped
   a_keep_awake: assert property ($past(presetn) && !s_q.pd |-> block_keep_on == 6'h3f)
      else $error("block off while awake");
   a_short_frame: assert property (sen_rise && s_q.frame != FR_FULL
      |=> $stable(s_q.regs) && $stable(s_q.ptr))
      else $error("short frame latched");
   a_addr_select: assert property (sen_rise && s_q.shift[2:0] == 3'h0 |=> s_q.sel)
      else $error("addressed strobe did not select");
   a_read_pin: assert property (s_q.rd && !s_q.regs[15][6]
      |=> !shared_lock_and_read_pin_oe || shared_lock_and_read_pin_o == $past(s_q.sdo_bit))
      else $error("read bit not on pin");
   a_read_drives: assert property (s_q.rd && s_q.regs[8][5] && !s_q.pd
      && s_q.regs[15][9:8] == 2'b00 |=> shared_lock_and_read_pin_oe)
      else $error("read not driven");

   // Main scenarios: read, write, forced drive, bus error, early strobe

   c_read: cover property (sclk_rise && s_q.sel ##[1:400] sen_rise && s_q.rd);
   c_write: cover property (sen_rise && s_q.frame == FR_FULL && s_q.shift[2:0] == 3'h0);
   c_force: cover property (shared_lock_and_read_pin_oe && !s_q.rd);
   c_apb_err: cover property (pready && pslverr);
   c_early_strobe: cover property (sen_rise && s_q.frame == FR_SHIFT && s_q.shift[2:0] == 3'h0);
endmodule // spm_top
`default_nettype wire
